// ---- ras_pkg.sv ----
// Package with constants of the return address stack
package ras_pkg;
    localparam int RAS_DEPTH = 4;
    localparam int RAS_PTR_W = 2;
    localparam int RAS_PC_W = 10;
    localparam int RAS_PCH_W = 2;
    localparam logic [7:0] RAS_ADDR_PTR = 8'hdf;
    localparam logic [7:0] RAS_ADDR_ENTRY_BASE = 8'hf0;
    localparam logic [7:0] RAS_ADDR_ENTRY_LAST = 8'hf7;
    localparam logic [1:0] RAS_PTR_EMPTY = 2'h3;
    localparam logic RAS_GIE_RESET = 1'h0;
    localparam int RAS_GIE_BIT = 7;
    localparam logic [9:0] RAS_PC_RESET = 10'h000;
endpackage : ras_pkg

// ---- ras_entry.sv ----
// One stack entry holding a saved program counter value
`timescale 1ns/1ps
module ras_entry
    import ras_pkg::*;
#(
    parameter int PC_W = RAS_PC_W
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_push_we,
    input wire logic [PC_W-1:0] i_push_pc,
    input wire logic i_hi_we,
    input wire logic i_lo_we,
    input wire logic [7:0] i_wdata,
    output logic [PC_W-1:0] o_pc
);
    typedef struct packed {
        logic [PC_W-1:0] pc;
    } ras_entry_st_t;

    ras_entry_st_t st;
    ras_entry_st_t next_st;

    always_comb begin
        next_st = st;
        if (i_push_we) begin
            next_st.pc = i_push_pc;
        end else begin
            if (i_hi_we) begin
                next_st.pc[PC_W-1:8] = i_wdata[PC_W-9:0];
            end
            if (i_lo_we) begin
                next_st.pc[7:0] = i_wdata;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_pc = st.pc;
endmodule : ras_entry

// ---- ras_stack.sv ----
// Return address stack with level pointer and global interrupt enable
`timescale 1ns/1ps
// Contract
// - Four stack levels, each saving one program counter value.
// - A 2-bit level pointer selects the entry for the next push or pop.
// - Push decrements the pointer and writes the PC at the new pointer.
// - Call or accepted interrupt pushes the PC before control transfers.
// - Return loads the PC from the latest entry and increments the pointer.
// - Entries come back in last-in, first-out order.
// - Empty is 11; one to four entries give 10, 01, 00, 11.
// - A fifth push wraps the pointer to 10, overwriting; no protection.
// - Entry split into high bits 9:8 and low bits 7:0; RW, reset zero.
// - Pointer register bit 7 is global interrupt enable, RW, reset 0.
// - Pointer bits reset to 11 and are software writable in bank 0.
// - The saved and restored program counter is 10 bits wide.
module ras_stack
    import ras_pkg::*;
#(
    parameter int DEPTH = RAS_DEPTH,
    parameter int PC_W = RAS_PC_W
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_call,
    input wire logic i_irq_take,
    input wire logic i_return,
    input wire logic [PC_W-1:0] i_next_pc,
    input wire logic i_reg_we,
    input wire logic i_reg_re,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic [PC_W-1:0] o_ret_pc,
    output logic o_ret_valid,
    output logic [RAS_PTR_W-1:0] o_level_ptr,
    output logic o_global_irq_enable
);
    typedef struct packed {
        logic [RAS_PTR_W-1:0] ptr;
        logic global_irq_enable;
        logic [PC_W-1:0] ret_pc;
        logic ret_valid;
        logic [7:0] rdata;
    } ras_st_t;

    ras_st_t st;
    ras_st_t next_st;
    logic [PC_W-1:0] entry_pc [DEPTH];
    logic [DEPTH-1:0] push_we;
    logic [DEPTH-1:0] hi_we;
    logic [DEPTH-1:0] lo_we;
    logic push;
    logic pop;
    logic [RAS_PTR_W-1:0] push_ptr;
    logic [7:0] ent_off;
    logic ent_hit;
    logic [RAS_PTR_W-1:0] ent_idx;

    // Call and interrupt share one push; a return in the same cycle is ignored
    assign push = i_call | i_irq_take;
    assign pop = i_return & ~push;
    assign push_ptr = st.ptr - 2'h1;
    assign ent_off = i_reg_addr - RAS_ADDR_ENTRY_BASE;
    assign ent_hit = (i_reg_addr >= RAS_ADDR_ENTRY_BASE) && (i_reg_addr <= RAS_ADDR_ENTRY_LAST);
    // Entry n: low at base+2n, high at base+2n+1
    assign ent_idx = ent_off[RAS_PTR_W:1];

    // Pointer 11 maps to entry 3, 10 to 0, 01 to 1, 00 to 2
    function automatic logic [RAS_PTR_W-1:0] ras_slot(input logic [RAS_PTR_W-1:0] p);
        ras_slot = RAS_PTR_W'(DEPTH - 2) - p;
    endfunction : ras_slot

    for (genvar n = 0; n < DEPTH; n++) begin : g_entry
        // Push writes the slot that the decremented pointer designates
        assign push_we[n] = push && (ras_slot(push_ptr) == RAS_PTR_W'(n));
        assign hi_we[n] = i_reg_we && ent_hit && ent_off[0] && (ent_idx == RAS_PTR_W'(n));
        assign lo_we[n] = i_reg_we && ent_hit && !ent_off[0] && (ent_idx == RAS_PTR_W'(n));
        ras_entry #(
            .PC_W(PC_W)
        ) u_entry (
            .i_sys_clk(i_sys_clk),
            .i_nrst(i_nrst),
            .i_push_we(push_we[n]),
            .i_push_pc(i_next_pc),
            .i_hi_we(hi_we[n]),
            .i_lo_we(lo_we[n]),
            .i_wdata(i_reg_wdata),
            .o_pc(entry_pc[n])
        );
    end

    always_comb begin
        next_st = st;
        next_st.ret_valid = 1'b0;
        if (i_reg_we && (i_reg_addr == RAS_ADDR_PTR)) begin
            next_st.ptr = i_reg_wdata[RAS_PTR_W-1:0];
            next_st.global_irq_enable = i_reg_wdata[RAS_GIE_BIT];
        end
        // Hardware stack motion wins over a software pointer write
        if (push) begin
            next_st.ptr = push_ptr;
        end else if (pop) begin
            next_st.ret_pc = entry_pc[ras_slot(st.ptr)];
            next_st.ret_valid = 1'b1;
            next_st.ptr = st.ptr + 2'h1;
        end
        next_st.rdata = 8'h00;
        if (i_reg_re) begin
            if (i_reg_addr == RAS_ADDR_PTR) begin
                next_st.rdata = {st.global_irq_enable, 5'h00, st.ptr};
            end else if (ent_hit) begin
                next_st.rdata = ent_off[0] ? {6'h00, entry_pc[ent_idx][PC_W-1:8]}
                                           : entry_pc[ent_idx][7:0];
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st.ptr <= RAS_PTR_EMPTY;
            st.global_irq_enable <= RAS_GIE_RESET;
            st.ret_pc <= RAS_PC_RESET;
            st.ret_valid <= 1'b0;
            st.rdata <= 8'h00;
        end else begin
            st <= next_st;
        end
    end

    assign o_reg_rdata = st.rdata;
    assign o_ret_pc = st.ret_pc;
    assign o_ret_valid = st.ret_valid;
    assign o_level_ptr = st.ptr;
    assign o_global_irq_enable = st.global_irq_enable;

    property p_push_dec;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        push |=> o_level_ptr == $past(o_level_ptr) - 2'h1;
    endproperty
    a_push_dec: assert property (p_push_dec) else $error("push did not decrement");

    property p_pop_inc;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        pop |=> (o_level_ptr == $past(o_level_ptr) + 2'h1) && o_ret_valid;
    endproperty
    a_pop_inc: assert property (p_pop_inc) else $error("pop did not increment");

    property p_lifo;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (push && !i_reg_we) ##1 (pop && !i_reg_we) |=> o_ret_pc == $past(i_next_pc, 2);
    endproperty
    a_lifo: assert property (p_lifo) else $error("pop did not return last push");

    property p_one_cycle;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        o_ret_valid |-> $past(pop);
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("stray return strobe");

    property p_wrap;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (push && o_level_ptr == 2'h3) |=> o_level_ptr == 2'h2;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pointer did not wrap to 10");

    property p_slot;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (push && o_level_ptr == 2'h1) |=> entry_pc[2] == $past(i_next_pc);
    endproperty
    a_slot: assert property (p_slot) else $error("push wrote wrong entry");

    property p_gie;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_reg_we && i_reg_addr == RAS_ADDR_PTR) |=> o_global_irq_enable == $past(i_reg_wdata[7]);
    endproperty
    a_gie: assert property (p_gie) else $error("enable bit not written");

    property p_swptr;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_reg_we && i_reg_addr == RAS_ADDR_PTR && !push && !pop)
            |=> o_level_ptr == $past(i_reg_wdata[1:0]);
    endproperty
    a_swptr: assert property (p_swptr) else $error("pointer not written");

    property p_hold;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (!push && !pop && !i_reg_we) |=> $stable(o_level_ptr);
    endproperty
    a_hold: assert property (p_hold) else $error("pointer moved on its own");

    property p_first_slot;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (push && o_level_ptr == 2'h3) |=> entry_pc[0] == $past(i_next_pc);
    endproperty
    a_first_slot: assert property (p_first_slot) else $error("first push missed entry 0");

    property p_ret_hold;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        !pop |=> $stable(o_ret_pc);
    endproperty
    a_ret_hold: assert property (p_ret_hold) else $error("restored pc changed");

    property p_gie_keep;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        !(i_reg_we && i_reg_addr == RAS_ADDR_PTR) |=> $stable(o_global_irq_enable);
    endproperty
    a_gie_keep: assert property (p_gie_keep) else $error("enable bit moved");

    property p_rd_ptr;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_reg_re && i_reg_addr == RAS_ADDR_PTR)
            |=> o_reg_rdata == {$past(o_global_irq_enable), 5'h00, $past(o_level_ptr)};
    endproperty
    a_rd_ptr: assert property (p_rd_ptr) else $error("pointer register read wrong");

    property p_rd_low0;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_reg_re && i_reg_addr == RAS_ADDR_ENTRY_BASE) |=> o_reg_rdata == $past(entry_pc[0][7:0]);
    endproperty
    a_rd_low0: assert property (p_rd_low0) else $error("entry low read wrong");

    c_push: cover property (@(posedge i_sys_clk) disable iff (!i_nrst) push);
    c_pop: cover property (@(posedge i_sys_clk) disable iff (!i_nrst) pop);
    c_wrap: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
        push && o_level_ptr == 2'h3);
    c_swr: cover property (@(posedge i_sys_clk) disable iff (!i_nrst) |hi_we);
    c_lifo: cover property (@(posedge i_sys_clk) disable iff (!i_nrst) push ##1 pop);
endmodule : ras_stack

// ---- ras_seq_model.sv ----
// Instruction sequencer model driving the stack control strobes
`timescale 1ns/1ps
module ras_seq_model
    import ras_pkg::*;
(
    input wire logic [2:0] i_op,
    input wire logic [RAS_PC_W-1:0] i_pc,
    output logic o_call,
    output logic o_irq_take,
    output logic o_return,
    output logic [RAS_PC_W-1:0] o_next_pc
);
    assign o_call = i_op[2];
    assign o_irq_take = i_op[1];
    assign o_return = i_op[0];
    // Scrambled off push cycles so a stale address never helps
    assign o_next_pc = (i_op[2] | i_op[1]) ? i_pc : ~i_pc;
endmodule : ras_seq_model

// ---- tb_top.sv ----
// Random and directed bench for the return address stack
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top;
    import ras_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [2:0] op = 3'h0;
    logic [9:0] pc = 10'h000;
    logic we = 1'b0;
    logic re = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic call, irq, ret, rv, global_irq_enable;
    logic [9:0] npc, rpc;
    logic [7:0] rdata;
    logic [1:0] lp;
    logic [1:0] m_ptr = 2'h3;
    logic m_gie = 1'b0;
    logic [9:0] m_ret = 10'h000;
    logic [9:0] m_ent [4] = '{default: 10'h000};
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int seed;
    int r;
    ras_seq_model u_seq (.i_op(op), .i_pc(pc), .o_call(call), .o_irq_take(irq),
        .o_return(ret), .o_next_pc(npc));
    ras_stack u_dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_call(call),
        .i_irq_take(irq), .i_return(ret), .i_next_pc(npc), .i_reg_we(we), .i_reg_re(re),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_ret_pc(rpc),
        .o_ret_valid(rv), .o_level_ptr(lp), .o_global_irq_enable(global_irq_enable));
    initial begin
        forever #50 i_sys_clk = ~i_sys_clk;
    end
    function automatic logic [7:0] rd_exp(input logic [7:0] a);
        if (a == RAS_ADDR_PTR) return {m_gie, 5'h00, m_ptr};
        if (a >= RAS_ADDR_ENTRY_BASE && a <= RAS_ADDR_ENTRY_LAST)
            return a[0] ? {6'h00, m_ent[a[2:1]][9:8]} : m_ent[a[2:1]][7:0];
        return 8'h00;
    endfunction : rd_exp
    // Stack op and register access are never mixed in one call
    task automatic cyc(input logic [2:0] o, input logic [9:0] p, input logic w,
        input logic rr, input logic [7:0] a, input logic [7:0] d);
        logic [7:0] ex_rd;
        logic ex_v;
        ex_rd = rr ? rd_exp(a) : 8'h00;
        ex_v = 1'b0;
        op = o;
        pc = p;
        we = w;
        re = rr;
        addr = a;
        wdata = d;
        if (o[2] | o[1]) begin
            m_ptr = m_ptr - 2'h1;
            m_ent[2'h2 - m_ptr] = p;
        end else if (o[0]) begin
            ex_v = 1'b1;
            m_ret = m_ent[2'h2 - m_ptr];
            m_ptr = m_ptr + 2'h1;
        end
        if (w && a == RAS_ADDR_PTR) begin
            m_gie = d[7];
            m_ptr = d[1:0];
        end else if (w && a >= RAS_ADDR_ENTRY_BASE && a <= RAS_ADDR_ENTRY_LAST) begin
            if (a[0]) m_ent[a[2:1]][9:8] = d[1:0];
            else m_ent[a[2:1]][7:0] = d;
        end
        @(posedge i_sys_clk);
        #1;
        `CHK("level_ptr", m_ptr, lp)
        `CHK("irq_enable", m_gie, global_irq_enable)
        `CHK("ret_valid", ex_v, rv)
        `CHK("ret_pc", m_ret, rpc)
        `CHK("reg_rdata", ex_rd, rdata)
    endtask : cyc
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            test_done();
        end
    end
    initial begin
        seed = 32'he392e6aa;
        repeat (6) @(posedge i_sys_clk);
        #1;
        i_nrst = 1'b1;
        // Reset values of all entries and the pointer register
        for (int k = 0; k < 9; k++) cyc(3'h0, 10'h000, 1'b0, 1'b1, 8'hf0 + k[7:0], 8'h00);
        cyc(3'h0, 10'h000, 1'b0, 1'b1, RAS_ADDR_PTR, 8'h00);
        cyc(3'h0, 10'h000, 1'b1, 1'b0, RAS_ADDR_PTR, 8'h03);
        // Five pushes by call, interrupt and both: the last one wraps
        for (int k = 0; k < 5; k++) cyc(k == 1 ? 3'h2 : k == 2 ? 3'h6 : 3'h4,
            10'h3a5 - 10'(k * 77), 1'b0, 1'b0, 8'h00, 8'h00);
        for (int k = 0; k < 8; k++) cyc(3'h0, 10'h000, 1'b0, 1'b1, 8'hf0 + k[7:0], 8'h00);
        // Return with a call in the same cycle loses to the push
        cyc(3'h5, 10'h2c1, 1'b0, 1'b0, 8'h00, 8'h00);
        for (int k = 0; k < 5; k++) cyc(3'h1, 10'h000, 1'b0, 1'b0, 8'h00, 8'h00);
        cyc(3'h0, 10'h000, 1'b1, 1'b0, RAS_ADDR_PTR, 8'h83);
        cyc(3'h0, 10'h000, 1'b0, 1'b1, RAS_ADDR_PTR, 8'h00);
        for (int k = 0; k < 400; k++) begin
            r = $random(seed);
            if (r[16]) r[15:8] = {5'h1e, r[10:8]};
            if (r[17]) r[15:8] = RAS_ADDR_PTR;
            case (r[2:0])
                3'h1, 3'h2, 3'h3: cyc({r[2:0] == 3'h1, r[2:0] == 3'h2, r[2:0] == 3'h3},
                    r[29:20], 1'b0, 1'b0, 8'h00, 8'h00);
                3'h4: cyc(3'h0, 10'h000, 1'b1, 1'b0, r[15:8], r[27:20]);
                3'h5, 3'h6: cyc(3'h0, 10'h000, 1'b0, 1'b1, r[15:8], 8'h00);
                default: cyc(3'h0, 10'h000, 1'b0, 1'b0, 8'h00, 8'h00);
            endcase
        end
        test_done();
    end
endmodule : tb_top
